// ### hdl/clock_ctrl.sv
// system clock source selection, pll programming and divider with key-protected registers
// assumes software alone drives the register port; pll lock arrives synchronous to clock_in
// Summary of operation
// - source select: 0 oscillator, 1 pll once the pll is enabled and locked
// - divider code gives divide by 2/4/8/16
// - pll source bypasses the divider
// - divided select 0 passes source through
// - pll code sets 51.204/64/38.403 mhz
// - code 11 gives 38.403 mhz undivided, divide select is ignored on pll source
// - lock flag reads 1 only when locked
// - hardware clears change strobe after apply
// - protected writes need three-key unlock first
// - pll enable bit powers pll up/down
`timescale 1ns/1ps
module clock_ctrl (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // register port
  input wire logic [clock_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clock_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [clock_ctrl_pkg::DATA_W-1:0] rdata_out,
  // pll interface
  input wire logic pll_locked_in,
  output clock_ctrl_pkg::pll_ctrl_t pll_ctrl_out,
  // system clock outputs
  output clock_ctrl_pkg::clk_sel_t clk_sel_out,
  output logic sys_clk_en_out
);
  import clock_ctrl_pkg::*;

  logic rst_meta_q;
  logic rst_sync_q;
  wire rstn = rst_sync_q;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  key_state_t key_q;
  key_state_t key_d;
  logic [7:0] div_cfg_q;
  logic [7:0] pll_cfg_q;
  logic chg_q;
  logic [APPLY_CNT_W-1:0] apply_cnt_q;
  logic [1:0] pll_n_active_q;
  logic [DATA_W-1:0] rdata_q;
  logic src_active_q;
  logic [DIV_CNT_W-1:0] limit_q;
  logic [DIV_CNT_W-1:0] cnt_q;
  logic en_q;

  // address decode
  wire hit_key = addr_in == KEY_UNLOCK_OFFSET;
  wire hit_div = addr_in == DIV_CFG_OFFSET;
  wire hit_pll = addr_in == PLL_CFG_OFFSET;
  wire wr_key = wr_in && hit_key;
  wire unlocked = key_q == KEY_OPEN;
  wire wr_div = wr_in && hit_div && unlocked;
  wire wr_pll = wr_in && hit_pll && unlocked;
  wire wr_prot = wr_in && (hit_div || hit_pll);

  // configuration fields
  wire pll_en = pll_cfg_q[PLL_EN_BIT];
  wire src_sel = pll_cfg_q[SRC_SEL_BIT];
  wire div_sel = pll_cfg_q[DIV_SEL_BIT];
  wire [1:0] div_code = div_cfg_q[DIV_CODE_MSB:DIV_CODE_LSB];
  wire lock_flag = pll_en && pll_locked_in;

  // key sequencer: each protected write, allowed or not, closes the lock again
  always_comb
  begin
    key_d = key_q;
    if (wr_key)
    begin
      case (key_q)
        KEY_IDLE: key_d = (wdata_in == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        KEY_GOT_FIRST: key_d = (wdata_in == KEY_SECOND) ? KEY_GOT_SECOND : KEY_IDLE;
        KEY_GOT_SECOND: key_d = (wdata_in == KEY_THIRD) ? KEY_OPEN : KEY_IDLE;
        KEY_OPEN: key_d = (wdata_in == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        default: key_d = KEY_IDLE;
      endcase
    end
    else if (wr_prot)
    begin
      key_d = KEY_IDLE;
    end
  end

  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
      key_q <= KEY_IDLE;
    else
      key_q <= key_d;
  end

  // control registers; lock bit is read-only and not stored
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cfg_q <= DIV_CFG_RESET;
      pll_cfg_q <= PLL_CFG_RESET;
    end
    else
    begin
      if (wr_div)
        div_cfg_q <= wdata_in;
      if (wr_pll)
        pll_cfg_q <= {1'b0, wdata_in[6:2], 1'b0, wdata_in[PLL_EN_BIT]};
    end
  end

  // change strobe: a new software request wins over the hardware clear
  wire chg_set = wr_pll && wdata_in[CHG_BIT];
  // the count starts at zero on the set edge, so the last apply cycle is one below the limit
  wire apply_done = chg_q && (apply_cnt_q == APPLY_CNT_W'(PLL_APPLY_CYCLES - 1));

  // strobe latches the code; self-clear after the apply time
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      chg_q <= 1'b0;
      apply_cnt_q <= '0;
      pll_n_active_q <= PLL_N_51M;
    end
    else if (chg_set)
    begin
      chg_q <= 1'b1;
      apply_cnt_q <= '0;
      // prohibited code is never passed on
      if (wdata_in[PLL_N_MSB:PLL_N_LSB] != PLL_N_BAD)
        pll_n_active_q <= wdata_in[PLL_N_MSB:PLL_N_LSB];
    end
    else if (apply_done)
    begin
      chg_q <= 1'b0;
    end
    else if (chg_q)
    begin
      apply_cnt_q <= apply_cnt_q + 1'b1;
    end
  end

  assign pll_ctrl_out.enable = pll_en;
  assign pll_ctrl_out.freq_code = pll_n_active_q;
  assign pll_ctrl_out.apply = chg_q;

  // wanted divide limit (divide-by minus one)
  wire want_src = src_sel && lock_flag;
  wire bypass = want_src || !div_sel;
  wire [DIV_CNT_W-1:0] want_limit = bypass ? '0 : DIV_CNT_W'((5'h2 << div_code) - 5'h1);

  // settings are taken only where the current period ends, so no runt period
  wire wrap = cnt_q == limit_q;
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      src_active_q <= 1'b0;
      limit_q <= '0;
      cnt_q <= '0;
      en_q <= 1'b0;
    end
    else
    begin
      en_q <= wrap;
      if (wrap)
      begin
        cnt_q <= '0;
        src_active_q <= want_src;
        limit_q <= want_limit;
      end
      else
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign clk_sel_out.source_pll = src_active_q;
  assign clk_sel_out.div_limit = limit_q;
  assign sys_clk_en_out = en_q;

  // read mux; key register and unmapped offsets read zero
  wire [7:0] pll_rd = {lock_flag, pll_cfg_q[6:2], chg_q, pll_cfg_q[PLL_EN_BIT]};
  wire [7:0] rd_mux = hit_div ? div_cfg_q : (hit_pll ? pll_rd : 8'h00);
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_in ? rd_mux : 8'h00;
  end
  assign rdata_out = rdata_q;

endmodule : clock_ctrl

// ### inc/clock_ctrl_pkg.sv
// constants, layouts and types for the system clock source and pll control block
// assumes an 8-bit register port and a single 20 MHz block clock
package clock_ctrl_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] KEY_UNLOCK_OFFSET = 8'heb;
  localparam logic [7:0] DIV_CFG_OFFSET = 8'hf9;
  localparam logic [7:0] PLL_CFG_OFFSET = 8'hfa;

  // values after reset
  localparam logic [7:0] DIV_CFG_RESET = 8'h01;
  localparam logic [7:0] PLL_CFG_RESET = 8'h00;

  // unlock key sequence
  localparam logic [7:0] KEY_FIRST = 8'h8f;
  localparam logic [7:0] KEY_SECOND = 8'h32;
  localparam logic [7:0] KEY_THIRD = 8'h50;

  // divider config field positions
  localparam int DIV_CODE_LSB = 5;
  localparam int DIV_CODE_MSB = 6;

  // pll config field positions
  localparam int LOCK_BIT = 7;
  localparam int PLL_N_LSB = 5;
  localparam int PLL_N_MSB = 6;
  localparam int DIV_SEL_BIT = 4;
  localparam int SRC_SEL_BIT = 2;
  localparam int CHG_BIT = 1;
  localparam int PLL_EN_BIT = 0;

  // pll frequency codes
  localparam logic [1:0] PLL_N_51M = 2'h0;
  localparam logic [1:0] PLL_N_BAD = 2'h1;
  localparam logic [1:0] PLL_N_64M = 2'h2;
  localparam logic [1:0] PLL_N_38M = 2'h3;

  // time given to the pll to take a new code, in ns, and as block clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int PLL_APPLY_NS = 400;
  localparam int PLL_APPLY_CYCLES = (PLL_APPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APPLY_CNT_W = 4;

  // divider counter width (largest divide is 16)
  localparam int DIV_CNT_W = 4;

  // key sequencer states
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_GOT_SECOND,
    KEY_OPEN
  } key_state_t;

  // control handed to the analog pll
  typedef struct packed {
    logic enable;
    logic [1:0] freq_code;
    logic apply;
  } pll_ctrl_t;

  // clock selection actually in use
  typedef struct packed {
    logic source_pll;
    logic [DIV_CNT_W-1:0] div_limit;
  } clk_sel_t;

endpackage : clock_ctrl_pkg

// ### sim/clock_ctrl_checker.sv
// port checks for clock_ctrl
// assumes a bind into clock_ctrl
`timescale 1ns/1ps
module clock_ctrl_checker (
  // clock, reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // pll and clock
  input wire logic pll_locked_in,
  input wire clock_ctrl_pkg::pll_ctrl_t pll_ctrl_out,
  input wire clock_ctrl_pkg::clk_sel_t clk_sel_out,
  input wire logic sys_clk_en_out
);
  import clock_ctrl_pkg::*;
  // short names for watched outputs
  wire en = sys_clk_en_out;
  wire [3:0] lim = clk_sel_out.div_limit;
  wire app = pll_ctrl_out.apply;
  // raw reset gates all checks
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  // idle cycles between pulses
  sequence gap1_s;
    !en ##1 en;
  endsequence
  sequence gap3_s;
    !en [*3] ##1 en;
  endsequence
  div_two_a: assert property (en && lim == 4'h1 |=> gap1_s)
    else $error("div2 period");
  div_four_a: assert property (en && lim == 4'h3 |=> gap3_s)
    else $error("div4 period");
  bypass_a: assert property (clk_sel_out.source_pll |-> lim == 4'h0)
    else $error("pll divided");
  no_glitch_a: assert property ($changed(clk_sel_out) |-> en)
    else $error("mid period switch");
  apply_len_a: assert property ($rose(app) |-> app [*8] ##1 !app)
    else $error("apply length");
  code_gate_a: assert property ($changed(pll_ctrl_out.freq_code) |->
    (app || $past(app)) && pll_ctrl_out.freq_code != PLL_N_BAD) else $error("code change");
  lock_read_a: assert property (rd_in && addr_in == PLL_CFG_OFFSET |=>
    rdata_out[7] == ($past(pll_locked_in) && $past(pll_ctrl_out.enable))) else $error("lock bit");
  key_once_a: assert property (wr_in && addr_in == DIV_CFG_OFFSET ##2 wr_in && addr_in == PLL_CFG_OFFSET |=>
    $stable(pll_ctrl_out.enable)) else $error("key reused");
endmodule : clock_ctrl_checker
// one checker per block
bind clock_ctrl clock_ctrl_checker u_chk (
  .clock_in(clock_in),
  .rstn_in(rstn_in),
  .addr_in(addr_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .pll_locked_in(pll_locked_in),
  .pll_ctrl_out(pll_ctrl_out),
  .clk_sel_out(clk_sel_out),
  .sys_clk_en_out(sys_clk_en_out)
);

// ### sim/tb.sv
// self-checking bench for clock_ctrl
// the bench plays software and the pll lock
`timescale 1ns/1ps
module tb;
  import clock_ctrl_pkg::*;
  // inputs, set at time zero
  logic clock_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, pll_locked_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00;
  logic [7:0] rdata_out;
  pll_ctrl_t pll_ctrl_out;
  clk_sel_t clk_sel_out;
  logic sys_clk_en_out;
  int n_mismatch = 0, compares = 0, cycles = 0;
  clock_ctrl u_clock_ctrl (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .pll_locked_in(pll_locked_in),
    .pll_ctrl_out(pll_ctrl_out),
    .clk_sel_out(clk_sel_out),
    .sys_clk_en_out(sys_clk_en_out)
  );
  // 50 ns period
  always #25 clock_in = ~clock_in;
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // hang guard; tests need under 1000 cycles
  always @(posedge clock_in)
    if (++cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one write, or a read judged against d; a gap cycle avoids double drives
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
    if (!w)
      chk("rdata", rdata_out, d);
  endtask : bus
  task automatic unlock();
    bus(1'b1, KEY_UNLOCK_OFFSET, KEY_FIRST);
    bus(1'b1, KEY_UNLOCK_OFFSET, KEY_SECOND);
    bus(1'b1, KEY_UNLOCK_OFFSET, KEY_THIRD);
  endtask : unlock
  // long enough for a divide by 16 and the apply time
  task automatic settle();
    repeat (40) @(posedge clock_in);
    #1;
  endtask : settle
  task automatic t_regs();
    bus(1'b0, DIV_CFG_OFFSET, DIV_CFG_RESET);
    bus(1'b0, PLL_CFG_OFFSET, PLL_CFG_RESET);
    bus(1'b0, 8'h10, 8'h00);
    chk("sel", 8'(clk_sel_out), 8'h00);
    bus(1'b1, KEY_UNLOCK_OFFSET, KEY_FIRST);
    bus(1'b1, KEY_UNLOCK_OFFSET, 8'h33);
    bus(1'b1, KEY_UNLOCK_OFFSET, KEY_THIRD);
    bus(1'b1, DIV_CFG_OFFSET, 8'h61);
    unlock();
    bus(1'b1, DIV_CFG_OFFSET, 8'h21);
    bus(1'b1, PLL_CFG_OFFSET, 8'h01);
    bus(1'b0, DIV_CFG_OFFSET, 8'h21);
    bus(1'b0, PLL_CFG_OFFSET, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_div();
    unlock();
    bus(1'b1, PLL_CFG_OFFSET, 8'h10);
    for (int c = 0; c < 4; c++)
    begin
      unlock();
      bus(1'b1, DIV_CFG_OFFSET, {1'b0, 2'(c), 5'h01});
      settle();
      chk("sel", 8'(clk_sel_out), 8'((2 << c) - 1));
    end
    $display("t_div done");
  endtask : t_div
  // each pll code, a refused code, power down
  task automatic t_pll();
    logic [1:0] codes [3] = '{PLL_N_51M, PLL_N_64M, PLL_N_38M};
    pll_locked_in <= 1'b1;
    foreach (codes[i])
    begin
      unlock();
      // divide select and strobe with the code
      bus(1'b1, PLL_CFG_OFFSET, {1'b0, codes[i], 5'h17});
      chk("apply", 8'(pll_ctrl_out), 8'({1'b1, codes[i], 1'b1}));
      settle();
      chk("pll", 8'(pll_ctrl_out), 8'({1'b1, codes[i], 1'b0}));
      chk("sel", 8'(clk_sel_out), 8'h10);
      bus(1'b0, PLL_CFG_OFFSET, {1'b1, codes[i], 5'h15});
    end
    unlock();
    bus(1'b1, PLL_CFG_OFFSET, {1'b0, PLL_N_BAD, 5'h17});
    settle();
    chk("pll", 8'(pll_ctrl_out), 8'h0e);
    // a new code without the strobe is stored but not passed on
    unlock();
    bus(1'b1, PLL_CFG_OFFSET, {1'b0, PLL_N_64M, 5'h15});
    settle();
    chk("pll", 8'(pll_ctrl_out), 8'h0e);
    unlock();
    bus(1'b1, PLL_CFG_OFFSET, 8'h10);
    settle();
    chk("pll", 8'(pll_ctrl_out), 8'h06);
    chk("sel", 8'(clk_sel_out), 8'h0f);
    bus(1'b0, PLL_CFG_OFFSET, 8'h10);
    $display("t_pll done");
  endtask : t_pll
  // two cycles of reset, then the tests
  initial
  begin
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_regs();
    t_div();
    t_pll();
    test_done();
  end
endmodule : tb
